// ===== logic/crs_alu.sv
// Adder for add and subtract with carry, binary or decimal corrected.
`timescale 1ns/100ps
`default_nettype none
module crs_alu
   import crs_pkg::*;
(
   input  wire logic [7:0]   a,
   input  wire logic [7:0]   b,
   input  wire logic         carryIn,
   input  wire logic         decimalMode,
   input  wire logic         subtract,
   output crs_alu_out_t      res
);
   logic [7:0] bb;
   logic [8:0] sum;
   logic [4:0] lowNib;
   logic [8:0] adj;

   always_comb begin
      bb     = subtract ? ~b : b;
      sum    = {1'b0, a} + {1'b0, bb} + {8'h00, carryIn};
      lowNib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, carryIn};
      adj    = sum;
      // In decimal mode only the result and carry are corrected; the other flags are
      // taken from the binary sum and are not meaningful.
      if (decimalMode) begin
         if (!subtract) begin
            if (lowNib > 5'd9) begin
               adj = adj + {1'b0, BCD_SIX};
            end
            if (adj > 9'h099) begin
               adj = {1'b1, adj[7:0] + BCD_SIXTY};
            end
         end else begin
            if (!lowNib[4]) begin
               adj = {adj[8], adj[7:0] - BCD_SIX};
            end
            if (!sum[8]) begin
               adj = {1'b0, adj[7:0] - BCD_SIXTY};
            end
         end
      end
      res.result = adj[7:0];
      res.c      = adj[8];
      res.z      = (sum[7:0] == 8'h00);
      res.v      = (a[7] == bb[7]) && (sum[7] != a[7]);
      res.n      = sum[7];
   end
endmodule
`default_nettype wire

// ===== logic/crs_core_regs.sv
// Programmer-visible register set with stack, flags and program counter.
//
// Our own choices: the address map and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - Eight-bit accumulator carries data operations.
// - First index adds operand for effective address.
// - Second index adds operand for effective address.
// - Eight-bit stack pointer marks stack location.
// - Stack address low byte is stack pointer.
// - Stack address high byte follows page bit.
// - Sixteen-bit counter of two bytes, next instruction.
// - Status register: four result, four control flags.
// - Branches test carry, zero, overflow, negative.
// - Decimal mode leaves zero, overflow, negative invalid.
// - Push and pop accumulator and flags.
// - Fast-set and slow-wait opcodes are unusable.
// - Stop, wait, multiply, divide are supported.
// - Flag bit order carry through negative.
// - Interrupt disable blocks all but break.
// - Decimal flag selects decimal add/subtract.
// - Page bit lives in mode register 003B.
module crs_core_regs
   import crs_pkg::*;
(
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire crs_bus_t     busReq,
   output logic [7:0]        busRdata,
   input  wire logic         cmdValid,
   input  wire crs_cmd_t     cmd,
   input  wire logic         irqReq,
   input  wire logic [15:0]  irqVector,
   output logic              cmdBusy,
   output logic              cmdDone,
   output logic [7:0]        accOut,
   output logic [7:0]        idxXOut,
   output logic [7:0]        idxYOut,
   output logic [7:0]        spOut,
   output logic [15:0]       pcOut,
   output logic [7:0]        flagsOut,
   output logic [15:0]       stackAddr,
   output logic [15:0]       eaX,
   output logic [15:0]       eaY,
   output logic              branchTaken,
   output logic              illegalOp,
   output logic              stopped,
   output logic              waiting,
   output logic              zvnValid
);

   // ==========================================================
   // State and stack storage
   crs_state_t   q;
   crs_state_t   d;
   crs_alu_out_t aluRes;
   logic [7:0]   stackMem [0:511];
   logic         memWe;
   logic [8:0]   memAddr;
   logic [7:0]   memData;
   logic [7:0]   popData;
   logic         accept;
   logic         irqGo;
   logic         condBit;
   logic [15:0]  product;
   logic [15:0]  pcNext;

   function automatic logic [7:0] read_reg(input crs_state_t s, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         ADDR_ACC:   r = s.acc;
         ADDR_IDXX:  r = s.idxX;
         ADDR_IDXY:  r = s.idxY;
         ADDR_SP:    r = s.sp;
         ADDR_PCLO:  r = s.pc[7:0];
         ADDR_PCHI:  r = s.pc[15:8];
         ADDR_FLAGS: r = s.flags;
         ADDR_CPU_MODE_CONTROL_REG:  r = s.cpuMode;
         default:    r = 8'h00;
      endcase
      return r;
   endfunction

   function automatic logic [8:0] stack_loc(input logic page, input logic [7:0] ptr);
      return {page, ptr};
   endfunction

   crs_alu u_alu (
      .a           (q.acc),
      .b           (cmd.operand),
      .carryIn     (q.flags[FLAG_C]),
      .decimalMode (q.flags[FLAG_D]),
      .subtract    (cmd.op == OP_SBC),
      .res         (aluRes)
   );

   // ==========================================================
   // Next-state logic
   always_comb begin
      d       = q;
      d.done  = 1'b0;
      d.taken = 1'b0;
      memWe   = 1'b0;
      memAddr = stack_loc(q.cpuMode[SPAGE_BIT], q.sp);
      memData = 8'h00;
      popData = stackMem[stack_loc(q.cpuMode[SPAGE_BIT], q.sp + 8'h01)];
      product = {8'h00, q.acc} * {8'h00, cmd.operand};
      pcNext  = q.pc + {14'h0000, cmd.pcStep};
      // A masked request still ends a stop or wait, but is not entered.
      irqGo   = (q.fsm == ST_IDLE) && irqReq && !q.flags[FLAG_I];
      accept  = cmdValid && (q.fsm == ST_IDLE) && !irqGo && !q.stopped && !q.waiting;
      unique case (cmd.aux[1:0])
         2'd0: condBit = q.flags[FLAG_C];
         2'd1: condBit = q.flags[FLAG_Z];
         2'd2: condBit = q.flags[FLAG_V];
         2'd3: condBit = q.flags[FLAG_N];
      endcase
      if (irqReq) begin
         d.stopped = 1'b0;
         d.waiting = 1'b0;
      end
      unique case (q.fsm)
         ST_IDLE: begin
            if (irqGo) begin
               d.brkEntry = 1'b0;
               d.fsm      = ST_PUSH_HI;
            end else if (accept) begin
               d.done    = 1'b1;
               d.illegal = 1'b0;
               d.pc      = pcNext;
               unique case (cmd.op)
                  OP_NOP:    d.illegal = 1'b0;
                  OP_LOAD_A: begin
                     d.acc          = cmd.operand;
                     d.flags[FLAG_Z] = (cmd.operand == 8'h00);
                     d.flags[FLAG_N] = cmd.operand[7];
                  end
                  OP_LOAD_X: d.idxX = cmd.operand;
                  OP_LOAD_Y: d.idxY = cmd.operand;
                  OP_LOAD_S: d.sp = cmd.operand;
                  OP_ADC, OP_SBC: begin
                     d.acc           = aluRes.result;
                     d.flags[FLAG_C] = aluRes.c;
                     d.flags[FLAG_Z] = aluRes.z;
                     d.flags[FLAG_V] = aluRes.v;
                     d.flags[FLAG_N] = aluRes.n;
                  end
                  OP_PUSH_A, OP_PUSH_P: begin
                     memWe   = 1'b1;
                     memData = (cmd.op == OP_PUSH_A) ? q.acc : q.flags;
                     d.sp    = q.sp - 8'h01;
                  end
                  OP_POP_A: begin
                     d.sp            = q.sp + 8'h01;
                     d.acc           = popData;
                     d.flags[FLAG_Z] = (popData == 8'h00);
                     d.flags[FLAG_N] = popData[7];
                  end
                  OP_POP_P: begin
                     d.sp            = q.sp + 8'h01;
                     d.flags         = popData;
                     d.flags[FLAG_B] = 1'b0;
                  end
                  OP_SET_FLAG, OP_CLR_FLAG: begin
                     // The break flag has no set or clear form and always reads zero.
                     if (cmd.aux != 3'(FLAG_B)) begin
                        d.flags[cmd.aux] = (cmd.op == OP_SET_FLAG);
                     end
                  end
                  OP_BRANCH: begin
                     if (condBit == cmd.aux[2]) begin
                        d.pc    = pcNext + {{8{cmd.operand[7]}}, cmd.operand};
                        d.taken = 1'b1;
                     end
                  end
                  OP_INDEX_X: d.eaX = {8'h00, cmd.operand} + {8'h00, q.idxX};
                  OP_INDEX_Y: d.eaY = {8'h00, cmd.operand} + {8'h00, q.idxY};
                  OP_FAST_SET, OP_SLOW_WAIT: begin
                     d.illegal = 1'b1;
                     d.pc      = q.pc;
                  end
                  OP_STOP: d.stopped = 1'b1;
                  OP_WAIT: d.waiting = 1'b1;
                  OP_MULTIPLY: begin
                     d.acc  = product[7:0];
                     d.idxY = product[15:8];
                  end
                  OP_DIVIDE: begin
                     // Division by zero leaves both registers untouched.
                     if (cmd.operand != 8'h00) begin
                        d.acc  = q.acc / cmd.operand;
                        d.idxY = q.acc % cmd.operand;
                     end
                  end
                  OP_BREAK: begin
                     d.brkEntry = 1'b1;
                     d.fsm      = ST_PUSH_HI;
                  end
                  default: d.illegal = 1'b1;
               endcase
            end
         end
         // Only the counter and flags are stacked on entry; the rest is up to software.
         ST_PUSH_HI: begin
            memWe   = 1'b1;
            memData = q.pc[15:8];
            d.sp    = q.sp - 8'h01;
            d.fsm   = ST_PUSH_LO;
         end
         ST_PUSH_LO: begin
            memWe   = 1'b1;
            memData = q.pc[7:0];
            d.sp    = q.sp - 8'h01;
            d.fsm   = ST_PUSH_PS;
         end
         ST_PUSH_PS: begin
            memWe           = 1'b1;
            memData         = q.flags;
            memData[FLAG_B] = q.brkEntry;
            d.sp            = q.sp - 8'h01;
            d.flags[FLAG_I] = 1'b1;
            d.pc            = irqVector;
            d.fsm           = ST_IDLE;
         end
         default: d.fsm = ST_IDLE;
      endcase
      // Software writes land after the command so that a write always sticks.
      if (busReq.wr) begin
         unique case (busReq.addr)
            ADDR_ACC:   d.acc = busReq.wdata;
            ADDR_IDXX:  d.idxX = busReq.wdata;
            ADDR_IDXY:  d.idxY = busReq.wdata;
            ADDR_SP:    d.sp = busReq.wdata;
            ADDR_PCLO:  d.pc[7:0] = busReq.wdata;
            ADDR_PCHI:  d.pc[15:8] = busReq.wdata;
            ADDR_FLAGS: d.flags = {busReq.wdata[7:5], 1'b0, busReq.wdata[3:0]};
            ADDR_CPU_MODE_CONTROL_REG:  d.cpuMode = busReq.wdata;
            default:    d.cpuMode = d.cpuMode;
         endcase
      end
      d.rdata     = busReq.rd ? read_reg(q, busReq.addr) : 8'h00;
      d.stackAddr = {7'h00, d.cpuMode[SPAGE_BIT], d.sp};
      d.busy      = (d.fsm != ST_IDLE);
      d.zvnValid  = !d.flags[FLAG_D];
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         q           <= '0;
         q.fsm       <= ST_IDLE;
         q.acc       <= RST_ACC;
         q.sp        <= RST_SP;
         q.pc        <= RST_PC;
         q.flags     <= RST_FLAGS;
         q.cpuMode   <= RST_CPU_MODE_CONTROL_REG;
         q.stackAddr <= {8'h00, RST_SP};
         q.zvnValid  <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // The stack area holds no reset; its contents are undefined until pushed.
   always_ff @(posedge clock) begin
      if (memWe) begin
         stackMem[memAddr] <= memData;
      end
   end

   assign busRdata    = q.rdata;
   assign cmdBusy     = q.busy;
   assign cmdDone     = q.done;
   assign accOut      = q.acc;
   assign idxXOut     = q.idxX;
   assign idxYOut     = q.idxY;
   assign spOut       = q.sp;
   assign pcOut       = q.pc;
   assign flagsOut    = q.flags;
   assign stackAddr   = q.stackAddr;
   assign eaX         = q.eaX;
   assign eaY         = q.eaY;
   assign branchTaken = q.taken;
   assign illegalOp   = q.illegal;
   assign stopped     = q.stopped;
   assign waiting     = q.waiting;
   assign zvnValid    = q.zvnValid;

   // ==========================================================
   // Checks
   property p_accLoad;
      @(posedge clock) disable iff (!rst_n)
      (accept && cmd.op == OP_LOAD_A && !busReq.wr) |=> (accOut == $past(cmd.operand));
   endproperty
   a_accLoad: assert property (p_accLoad) else $error("accumulator load lost");

   property p_indexX;
      @(posedge clock) disable iff (!rst_n)
      (accept && cmd.op == OP_INDEX_X) |=> (eaX == $past(cmd.operand) + $past(idxXOut));
   endproperty
   a_indexX: assert property (p_indexX) else $error("first index address wrong");

   property p_indexY;
      @(posedge clock) disable iff (!rst_n)
      (accept && cmd.op == OP_INDEX_Y) |=> (eaY == $past(cmd.operand) + $past(idxYOut));
   endproperty
   a_indexY: assert property (p_indexY) else $error("second index address wrong");

   property p_stackLow;
      @(posedge clock) disable iff (!rst_n)
      stackAddr[7:0] == spOut;
   endproperty
   a_stackLow: assert property (p_stackLow) else $error("stack low byte wrong");

   property p_stackHigh;
      @(posedge clock) disable iff (!rst_n)
      stackAddr[15:8] == (q.cpuMode[SPAGE_BIT] ? 8'h01 : 8'h00);
   endproperty
   a_stackHigh: assert property (p_stackHigh) else $error("stack page wrong");

   property p_pushDec;
      @(posedge clock) disable iff (!rst_n)
      (accept && cmd.op == OP_PUSH_A && !busReq.wr) |=> (spOut == $past(spOut) - 8'h01);
   endproperty
   a_pushDec: assert property (p_pushDec) else $error("push did not decrement");

   property p_masked;
      @(posedge clock) disable iff (!rst_n)
      (q.fsm == ST_IDLE && irqReq && q.flags[FLAG_I] && !(cmdValid && cmd.op == OP_BREAK))
         |=> !cmdBusy;
   endproperty
   a_masked: assert property (p_masked) else $error("masked request entered");

   property p_entry;
      @(posedge clock) disable iff (!rst_n)
      irqGo |=> cmdBusy [*3] ##1 (!cmdBusy && flagsOut[FLAG_I]);
   endproperty
   a_entry: assert property (p_entry) else $error("entry sequence length wrong");

   property p_illegal;
      @(posedge clock) disable iff (!rst_n)
      (accept && cmd.op == OP_FAST_SET && !busReq.wr) |=> (illegalOp && $stable(accOut));
   endproperty
   a_illegal: assert property (p_illegal) else $error("unusable opcode ran");

   property p_breakZero;
      @(posedge clock) disable iff (!rst_n)
      !flagsOut[FLAG_B];
   endproperty
   a_breakZero: assert property (p_breakZero) else $error("break flag held one");

endmodule
`default_nettype wire

// ===== logic/crs_pkg.sv
// Constants and types shared by the CPU register set.
`default_nettype none
package crs_pkg;

   // ==========================================================
   // Register map seen from the software port
   localparam logic [7:0] ADDR_ACC   = 8'h00;
   localparam logic [7:0] ADDR_IDXX  = 8'h01;
   localparam logic [7:0] ADDR_IDXY  = 8'h02;
   localparam logic [7:0] ADDR_SP    = 8'h03;
   localparam logic [7:0] ADDR_PCLO  = 8'h04;
   localparam logic [7:0] ADDR_PCHI  = 8'h05;
   localparam logic [7:0] ADDR_FLAGS = 8'h06;
   localparam logic [7:0] ADDR_CPU_MODE_CONTROL_REG  = 8'h3b;

   // ==========================================================
   // Field positions
   localparam int FLAG_C     = 0;
   localparam int FLAG_Z     = 1;
   localparam int FLAG_I     = 2;
   localparam int FLAG_D     = 3;
   localparam int FLAG_B     = 4;
   localparam int FLAG_T     = 5;
   localparam int FLAG_V     = 6;
   localparam int FLAG_N     = 7;
   localparam int SPAGE_BIT  = 2;

   // ==========================================================
   // Reset values and decimal correction constants
   localparam logic [7:0]  RST_ACC   = 8'h00;
   localparam logic [7:0]  RST_SP    = 8'hff;
   localparam logic [7:0]  RST_FLAGS = 8'h04;
   localparam logic [15:0] RST_PC    = 16'h0000;
   localparam logic [7:0]  RST_CPU_MODE_CONTROL_REG  = 8'h00;
   localparam logic [7:0]  BCD_SIX   = 8'h06;
   localparam logic [7:0]  BCD_SIXTY = 8'h60;

   // ==========================================================
   // Commands and sequencer states
   typedef enum logic [4:0] {
      OP_NOP       = 5'h00,
      OP_LOAD_A    = 5'h01,
      OP_LOAD_X    = 5'h02,
      OP_LOAD_Y    = 5'h03,
      OP_LOAD_S    = 5'h04,
      OP_ADC       = 5'h05,
      OP_SBC       = 5'h06,
      OP_PUSH_A    = 5'h07,
      OP_POP_A     = 5'h08,
      OP_PUSH_P    = 5'h09,
      OP_POP_P     = 5'h0a,
      OP_SET_FLAG  = 5'h0b,
      OP_CLR_FLAG  = 5'h0c,
      OP_BRANCH    = 5'h0d,
      OP_INDEX_X   = 5'h0e,
      OP_INDEX_Y   = 5'h0f,
      OP_FAST_SET  = 5'h10,
      OP_SLOW_WAIT = 5'h11,
      OP_STOP      = 5'h12,
      OP_WAIT      = 5'h13,
      OP_MULTIPLY  = 5'h14,
      OP_DIVIDE    = 5'h15,
      OP_BREAK     = 5'h16
   } crs_op_t;

   typedef enum logic [3:0] {
      ST_IDLE    = 4'b0001,
      ST_PUSH_HI = 4'b0010,
      ST_PUSH_LO = 4'b0100,
      ST_PUSH_PS = 4'b1000
   } crs_fsm_t;

   // ==========================================================
   // Carriers
   typedef struct packed {
      crs_op_t    op;
      logic [7:0] operand;
      logic [2:0] aux;
      logic [1:0] pcStep;
   } crs_cmd_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } crs_bus_t;

   typedef struct packed {
      logic [7:0] result;
      logic       c;
      logic       z;
      logic       v;
      logic       n;
   } crs_alu_out_t;

   typedef struct packed {
      crs_fsm_t    fsm;
      logic [7:0]  acc;
      logic [7:0]  idxX;
      logic [7:0]  idxY;
      logic [7:0]  sp;
      logic [15:0] pc;
      logic [7:0]  flags;
      logic [7:0]  cpuMode;
      logic        brkEntry;
      logic [7:0]  rdata;
      logic [15:0] eaX;
      logic [15:0] eaY;
      logic [15:0] stackAddr;
      logic        busy;
      logic        done;
      logic        taken;
      logic        illegal;
      logic        stopped;
      logic        waiting;
      logic        zvnValid;
   } crs_state_t;

endpackage
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking testbench for the CPU register set.
`timescale 1ns/100ps
`default_nettype none
module testbench
   import crs_pkg::*;
;
   logic        clock;
   logic        rst_n;
   crs_bus_t    busReq;
   logic [7:0]  busRdata;
   logic        cmdValid;
   crs_cmd_t    cmd;
   logic        irqReq;
   logic [15:0] irqVector;
   logic        cmdBusy;
   logic        cmdDone;
   logic [7:0]  accOut;
   logic [7:0]  idxXOut;
   logic [7:0]  idxYOut;
   logic [7:0]  spOut;
   logic [15:0] pcOut;
   logic [7:0]  flagsOut;
   logic [15:0] stackAddr;
   logic [15:0] eaX;
   logic [15:0] eaY;
   logic        branchTaken;
   logic        illegalOp;
   logic        stopped;
   logic        waiting;
   logic        zvnValid;
   logic [7:0]  rnd;
   logic [7:0]  a;
   logic [7:0]  b;
   logic [7:0]  o;
   logic [7:0]  s;
   logic [7:0]  f;
   logic [7:0]  d;
   logic [15:0] pv;
   logic        tk;
   int          k;
   int          cycles;
   int          errors;
   int          samplesChecked;
   logic [7:0]  regMap [7] = '{ADDR_ACC, ADDR_IDXX, ADDR_IDXY, ADDR_SP, ADDR_PCLO, ADDR_PCHI,
                               ADDR_FLAGS};
   int          posTab [4] = '{FLAG_C, FLAG_Z, FLAG_V, FLAG_N};

   crs_core_regs dut_u (.clock(clock), .rst_n(rst_n), .busReq(busReq), .busRdata(busRdata),
      .cmdValid(cmdValid), .cmd(cmd), .irqReq(irqReq), .irqVector(irqVector),
      .cmdBusy(cmdBusy), .cmdDone(cmdDone), .accOut(accOut), .idxXOut(idxXOut),
      .idxYOut(idxYOut), .spOut(spOut), .pcOut(pcOut), .flagsOut(flagsOut),
      .stackAddr(stackAddr), .eaX(eaX), .eaY(eaY), .branchTaken(branchTaken),
      .illegalOp(illegalOp), .stopped(stopped), .waiting(waiting), .zvnValid(zvnValid));

   // ==========================================================
   // Clock, timeout and shared tasks
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // Ceiling sits far above the few hundred cycles the sequence needs.
   always @(posedge clock) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         $display("wrong value at %0t: run timed out", $time);
         wrapUp();
      end
   end

   function automatic logic [7:0] next8();
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      return rnd;
   endfunction

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      samplesChecked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] dat);
      @(posedge clock);
      busReq <= '{addr: ad, wdata: dat, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      busReq.wr <= 1'b0;
      #1;
   endtask

   // Read data is only valid in the one cycle after the strobe edge.
   task automatic rd(input logic [7:0] ad, output logic [7:0] dat);
      @(posedge clock);
      busReq <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      busReq.rd <= 1'b0;
      #1 dat = busRdata;
   endtask

   task automatic run(input crs_op_t op, input logic [7:0] opd, input logic [2:0] aux,
                      input logic [1:0] st, input logic expDone);
      @(posedge clock);
      cmdValid <= 1'b1;
      cmd <= '{op: op, operand: opd, aux: aux, pcStep: st};
      @(posedge clock);
      cmdValid <= 1'b0;
      #1 chk(cmdDone, expDone, "command done");
   endtask

   task automatic waitEntry();
      int n;
      n = 0;
      while (cmdBusy !== 1'b1 && n < 8) begin
         @(posedge clock);
         #1 n++;
      end
      while (cmdBusy !== 1'b0 && n < 16) begin
         @(posedge clock);
         #1 n++;
      end
      chk(cmdBusy, 1'b0, "entry end");
   endtask

   task automatic wrapUp();
      $display("comparisons %0d, mismatches %0d", samplesChecked, errors);
      if (errors == 0 && samplesChecked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      rnd = 8'h5d;
      cycles = 0;
      errors = 0;
      samplesChecked = 0;
      busReq = '0;
      cmdValid = 1'b0;
      cmd = '0;
      irqReq = 1'b0;
      irqVector = 16'h0000;
      rst_n = 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      #1 chk(spOut, RST_SP, "sp reset");
      chk(flagsOut, RST_FLAGS, "flags reset");
      chk(stackAddr, 16'h00ff, "stack reset");
      chk(pcOut, RST_PC, "pc reset");
      rd(ADDR_CPU_MODE_CONTROL_REG, d);
      chk(d, RST_CPU_MODE_CONTROL_REG, "mode reset");
      rd(8'h20, d);
      chk(d, 8'h00, "unmapped read");
      $display("reset test done");
      for (k = 0; k < 7; k++) begin
         a = next8();
         wr(regMap[k], a);
         rd(regMap[k], d);
         chk(d, (k == 6) ? (a & 8'hef) : a, "register readback");
      end
      for (k = 0; k < 2; k++) begin
         s = next8();
         wr(ADDR_SP, s);
         wr(ADDR_CPU_MODE_CONTROL_REG, k[0] ? (8'h01 << SPAGE_BIT) : 8'h00);
         chk(stackAddr, {7'h00, k[0], s}, "stack address");
      end
      for (k = 0; k < 4; k++) begin
         a = next8();
         o = next8();
         wr(k[0] ? ADDR_IDXY : ADDR_IDXX, a);
         run(k[0] ? OP_INDEX_Y : OP_INDEX_X, o, 3'h0, 2'h0, 1'b1);
         chk(k[0] ? eaY : eaX, {7'h00, {1'b0, a} + {1'b0, o}}, "index sum");
         run(crs_op_t'(OP_LOAD_A + k), o, 3'h0, 2'h1, 1'b1);
         chk(k[1] ? (k[0] ? spOut : idxYOut) : (k[0] ? idxXOut : accOut), o, "load");
      end
      $display("register test done");
      s = next8();
      a = next8();
      b = next8();
      wr(ADDR_SP, s);
      wr(ADDR_ACC, a);
      run(OP_PUSH_A, 8'h00, 3'h0, 2'h1, 1'b1);
      chk(spOut, 8'(s - 8'h01), "sp after push");
      wr(ADDR_ACC, b);
      run(OP_PUSH_A, 8'h00, 3'h0, 2'h1, 1'b1);
      wr(ADDR_ACC, ~b);
      run(OP_POP_A, 8'h00, 3'h0, 2'h1, 1'b1);
      chk(accOut, b, "pop order");
      run(OP_POP_A, 8'h00, 3'h0, 2'h1, 1'b1);
      chk(accOut, a, "pop first");
      chk(spOut, s, "sp after pops");
      f = next8() & 8'hef;
      wr(ADDR_FLAGS, f);
      run(OP_PUSH_P, 8'h00, 3'h0, 2'h1, 1'b1);
      wr(ADDR_FLAGS, ~f);
      run(OP_POP_P, 8'h00, 3'h0, 2'h1, 1'b1);
      chk(flagsOut, f, "flags pop");
      $display("stack test done");
      for (k = 0; k < 8; k++) begin
         f = next8() & 8'hef;
         pv = {next8(), next8()};
         o = next8();
         d = next8();
         wr(ADDR_FLAGS, f);
         wr(ADDR_PCLO, pv[7:0]);
         wr(ADDR_PCHI, pv[15:8]);
         tk = (f[posTab[k % 4]] == k[2]);
         run(OP_BRANCH, o, k[2:0], d[1:0], 1'b1);
         chk(branchTaken, tk, "branch decision");
         chk(pcOut, pv + {14'h0, d[1:0]} + (tk ? {{8{o[7]}}, o} : 16'h0000), "pc");
         chk(zvnValid, !f[FLAG_D], "zvn valid");
      end
      $display("branch test done");
      a = next8();
      o = next8();
      wr(ADDR_FLAGS, 8'h00);
      wr(ADDR_ACC, a);
      run(OP_ADC, o, 3'h0, 2'h1, 1'b1);
      chk(accOut, 8'(a + o), "binary add");
      wr(ADDR_FLAGS, 8'h01);
      wr(ADDR_ACC, a);
      run(OP_SBC, o, 3'h0, 2'h1, 1'b1);
      chk(accOut, 8'(a - o), "binary subtract");
      wr(ADDR_FLAGS, 8'h00);
      run(OP_SET_FLAG, 8'h00, 3'(FLAG_D), 2'h1, 1'b1);
      run(OP_SET_FLAG, 8'h00, 3'(FLAG_B), 2'h1, 1'b1);
      chk(flagsOut, 8'h08, "set decimal only");
      wr(ADDR_ACC, 8'h58);
      run(OP_ADC, 8'h46, 3'h0, 2'h1, 1'b1);
      chk({flagsOut[FLAG_C], accOut}, 9'h104, "decimal add");
      run(OP_CLR_FLAG, 8'h00, 3'(FLAG_D), 2'h1, 1'b1);
      chk({flagsOut[FLAG_D], zvnValid}, 2'b01, "clear decimal");
      $display("arithmetic test done");
      for (k = 0; k < 2; k++) begin
         wr(ADDR_PCLO, 8'h40);
         run(k[0] ? OP_SLOW_WAIT : OP_FAST_SET, 8'h00, 3'h0, 2'h1, 1'b1);
         chk({illegalOp, pcOut[7:0]}, 9'h140, "unusable opcode");
      end
      a = next8();
      b = next8();
      wr(ADDR_ACC, a);
      run(OP_MULTIPLY, b, 3'h0, 2'h1, 1'b1);
      chk({idxYOut, accOut}, {8'h00, a} * {8'h00, b}, "multiply");
      b = b | 8'h01;
      wr(ADDR_ACC, a);
      run(OP_DIVIDE, b, 3'h0, 2'h1, 1'b1);
      chk({idxYOut, accOut}, {a % b, a / b}, "divide");
      wr(ADDR_FLAGS, 8'h04);
      for (k = 0; k < 2; k++) begin
         run(k[0] ? OP_WAIT : OP_STOP, 8'h00, 3'h0, 2'h1, 1'b1);
         chk(k[0] ? waiting : stopped, 1'b1, "halted");
         run(OP_NOP, 8'h00, 3'h0, 2'h1, 1'b0);
         irqReq <= 1'b1;
         @(posedge clock);
         irqReq <= 1'b0;
         #1 chk(k[0] ? waiting : stopped, 1'b0, "woken");
      end
      $display("instruction group test done");
      // Masked request: commands still run and no entry starts.
      irqReq <= 1'b1;
      run(OP_NOP, 8'h00, 3'h0, 2'h1, 1'b1);
      chk({cmdBusy, illegalOp}, 2'b00, "masked request");
      irqReq <= 1'b0;
      for (k = 0; k < 2; k++) begin
         s = next8();
         pv = {next8(), next8()};
         f = next8() & 8'hea;
         wr(ADDR_SP, s);
         wr(ADDR_FLAGS, k[0] ? (f | 8'h04) : f);
         irqVector <= pv;
         if (k[0]) begin
            run(OP_BREAK, 8'h00, 3'h0, 2'h2, 1'b1);
         end else begin
            irqReq <= 1'b1;
         end
         waitEntry();
         irqReq <= 1'b0;
         chk(pcOut, pv, "vector");
         chk({flagsOut[FLAG_I], spOut}, {1'b1, s - 8'h03}, "entry state");
         run(OP_POP_P, 8'h00, 3'h0, 2'h1, 1'b1);
         chk(flagsOut, k[0] ? (f | 8'h04) : f, "stacked flags");
      end
      $display("interrupt test done");
      wrapUp();
   end
endmodule
`default_nettype wire
